// [core/tsm_pkg.sv]
// shared constants for the thermometer/thermostat core
package tsm_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_HIGH_TRIP = 5'h08;
  localparam logic [4:0] OFS_LOW_TRIP = 5'h0c;
  localparam logic [4:0] OFS_CONFIG = 5'h10;
  localparam logic [4:0] OFS_COUNTER = 5'h14;
  localparam logic [4:0] OFS_SLOPE = 5'h18;
  // control bits
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 1;
  // config bits
  localparam int CFG_MODE = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_SINGLE = 2;
  localparam int CFG_HIFLAG = 3;
  localparam int CFG_LOFLAG = 4;
  // status bits above the 8-bit result
  localparam int STS_BUSY = 8;
  localparam int STS_DONE = 9;
  localparam int STS_MODE = 10;
  localparam int STS_RUN = 11;
  // nonvolatile slots
  localparam logic [1:0] NV_HIGH = 2'h0;
  localparam logic [1:0] NV_LOW = 2'h1;
  localparam logic [1:0] NV_CFG = 2'h2;
  // temperature codes
  localparam logic [7:0] TEMP_MIN = 8'hc9;
  localparam logic [7:0] TEMP_MAX = 8'h7d;
  // factory contents of nonvolatile storage
  localparam logic [7:0] FACTORY_HIGH = 8'h7d;
  localparam logic [7:0] FACTORY_LOW = 8'hc9;
  localparam logic [2:0] FACTORY_CFG = 3'h0;
  // measurement loop defaults
  localparam logic [8:0] BASE_COUNT = 9'h0_0c8;
  localparam logic [8:0] SLOPE_INIT = 9'h0_040;
  localparam logic [8:0] SLOPE_STEP = 9'h0_001;
  localparam logic [15:0] GATE_TICKS = 16'h0_400;
  // timing
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint NV_WRITE_MS = 10;
  localparam longint NV_WRITE_CYCLES = (NV_WRITE_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [4:0] RESTORE_PULSES = 5'h10;
endpackage

// [core/tsm_measure.sv]
// iterative counter-based temperature conversion loop
`timescale 1ns/1ps
module tsm_measure
  import tsm_pkg::*;
#(
  parameter int CW = 9
)(
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic lo_tick,
  input wire logic hi_tick,
  // results
  output logic busy,
  output logic done,
  output logic [7:0] temp,
  output logic [CW-1:0] count_remain,
  output logic [CW-1:0] slope_value
);
  typedef enum logic {ST_IDLE, ST_RUN} tsm_meas_type;
  tsm_meas_type state_reg;
  logic [15:0] gate_reg;
  logic [CW-1:0] step_reg;
  logic gate_end;

  assign gate_end = hi_tick && (gate_reg == GATE_TICKS - 16'h0_001);
  assign busy = (state_reg == ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      done <= 1'b0;
      gate_reg <= 16'h0_000;
    end
    else if (ce)
    begin
      done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          gate_reg <= 16'h0_000;
          if (start)
            state_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          if (hi_tick)
            gate_reg <= gate_reg + 16'h0_001;
          if (gate_end)
          begin
            state_reg <= ST_IDLE;
            done <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // counter, slope accumulator and temperature register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      temp <= TEMP_MIN;
      count_remain <= BASE_COUNT;
      slope_value <= SLOPE_INIT;
      step_reg <= SLOPE_STEP;
    end
    else if (ce)
    begin
      if (state_reg == ST_IDLE && start)
      begin
        temp <= TEMP_MIN;
        count_remain <= BASE_COUNT;
        slope_value <= SLOPE_INIT;
        step_reg <= SLOPE_STEP;
      end
      else if (state_reg == ST_RUN && !gate_end && lo_tick)
      begin
        if (count_remain == '0)
        begin
          // saturate so the code never wraps past the top of range
          if (temp != TEMP_MAX)
            temp <= temp + 8'h01;
          count_remain <= slope_value;
          // growing step bends the reload curve per degree
          slope_value <= slope_value + step_reg;
          step_reg <= step_reg + SLOPE_STEP;
        end
        else
          count_remain <= count_remain - 1'b1;
      end
    end
  end
endmodule

// [core/tsm_nv_store.sv]
// nonvolatile trip points and configuration with slow write timing
`timescale 1ns/1ps
module tsm_nv_store
  import tsm_pkg::*;
#(
  parameter longint WRITE_CYCLES = NV_WRITE_CYCLES
)(
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write request
  input wire logic wr_req,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  // stored values
  output logic [7:0] high_trip_point,
  output logic [7:0] low_trip_point,
  output logic [2:0] cfg_bits,
  output logic nonvolatile_write_busy
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  // contents are not touched by reset: they model storage that outlives power
  logic [7:0] high_reg = FACTORY_HIGH;
  logic [7:0] low_reg = FACTORY_LOW;
  logic [2:0] cfg_reg = FACTORY_CFG;
  logic [TW-1:0] timer_reg;
  logic [1:0] sel_reg;
  logic [7:0] data_reg;

  assign high_trip_point = high_reg;
  assign low_trip_point = low_reg;
  assign cfg_bits = cfg_reg;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_reg <= '0;
      nonvolatile_write_busy <= 1'b0;
      sel_reg <= NV_HIGH;
      data_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (!nonvolatile_write_busy && wr_req)
      begin
        // a second write during a busy period is dropped, never merged
        nonvolatile_write_busy <= 1'b1;
        timer_reg <= TW'(WRITE_CYCLES - 1);
        sel_reg <= wr_sel;
        data_reg <= wr_data;
      end
      else if (nonvolatile_write_busy)
      begin
        if (timer_reg == '0)
          nonvolatile_write_busy <= 1'b0;
        else
          timer_reg <= timer_reg - 1'b1;
      end
    end
  end

  // committed only at the end, so a read shows the old value meanwhile
  always_ff @(posedge aclk)
  begin
    if (ce && aresetn && nonvolatile_write_busy && timer_reg == '0)
    begin
      if (sel_reg == NV_HIGH)
        high_reg <= data_reg;
      if (sel_reg == NV_LOW)
        low_reg <= data_reg;
      if (sel_reg == NV_CFG)
        cfg_reg <= data_reg[2:0];
    end
  end
endmodule

// [core/tsm_core.sv]
// thermometer/thermostat core: axi4-lite registers, modes, trip logic
`timescale 1ns/1ps
module tsm_core
  import tsm_pkg::*;
#(
  parameter longint NV_CYCLES = NV_WRITE_CYCLES
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // oscillators and supply sense
  input wire logic lo_tc_osc,
  input wire logic hi_tc_osc,
  input wire logic supply_low,
  // open-drain data pin and bus-side pull request
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  input wire logic bus_pull_low
);
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pins_in;
  logic lo_tick, hi_tick, dq_fall;
  logic aw_held_reg, w_held_reg;
  logic [4:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire, start_pulse, stop_pulse, nv_req;
  logic [1:0] nv_sel;
  logic [7:0] high_trip_point, low_trip_point;
  logic [2:0] cfg_bits;
  logic nonvolatile_write_busy;
  logic meas_busy, meas_done, meas_start;
  logic [7:0] meas_temp;
  logic [8:0] count_remain, slope_value;
  logic [7:0] result_reg;
  logic run_reg, done_reg, thermostat_reg, power_up_reg, therm_active_reg;
  logic high_limit_flag = 1'b0;
  logic low_limit_flag = 1'b0;
  logic [4:0] pulse_cnt_reg;
  logic output_active_level, single_conversion_select;

  assign pins_in = {supply_low, dq_in, hi_tc_osc, lo_tc_osc};
  assign output_active_level = cfg_bits[CFG_POL];
  assign single_conversion_select = cfg_bits[CFG_SINGLE];

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, then one more stage for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end
        else if (ce)
        begin
          sync1_reg[gi] <= pins_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  assign lo_tick = sync2_reg[0] && !sync3_reg[0];
  assign hi_tick = sync2_reg[1] && !sync3_reg[1];
  assign dq_fall = !sync2_reg[2] && sync3_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_bresp = 2'b00;

  // decode of the write that fires this cycle; byte 0 carries every field
  always_comb
  begin
    start_pulse = 1'b0;
    stop_pulse = 1'b0;
    nv_req = 1'b0;
    nv_sel = NV_HIGH;
    if (wr_fire && w_strb_reg[0])
    begin
      case (aw_addr_reg & 5'h1c)
        OFS_CONTROL:
        begin
          start_pulse = w_data_reg[CTL_START];
          stop_pulse = w_data_reg[CTL_STOP];
        end
        OFS_HIGH_TRIP: nv_req = 1'b1;
        OFS_LOW_TRIP:
        begin
          nv_req = 1'b1;
          nv_sel = NV_LOW;
        end
        OFS_CONFIG:
        begin
          nv_req = 1'b1;
          nv_sel = NV_CFG;
        end
        default: nv_req = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel, one cycle from address to data
  function automatic logic [31:0] read_word(input logic [4:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr & 5'h1c)
      OFS_STATUS:
      begin
        v[7:0] = result_reg;
        v[STS_BUSY] = nonvolatile_write_busy;
        v[STS_DONE] = done_reg;
        v[STS_MODE] = thermostat_reg;
        v[STS_RUN] = run_reg;
      end
      OFS_HIGH_TRIP: v[7:0] = high_trip_point;
      OFS_LOW_TRIP: v[7:0] = low_trip_point;
      OFS_CONFIG: v[4:0] = {low_limit_flag, high_limit_flag, cfg_bits};
      OFS_COUNTER: v[8:0] = count_remain;
      OFS_SLOPE: v[8:0] = slope_value;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word(s_axi_araddr);
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_rresp = 2'b00;

  ////////////////////////////////////////////////////////////////////////
  tsm_nv_store #(
    .WRITE_CYCLES(NV_CYCLES)
  ) u_nv (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .wr_req(nv_req),
    .wr_sel(nv_sel),
    .wr_data(w_data_reg[7:0]),
    .high_trip_point(high_trip_point),
    .low_trip_point(low_trip_point),
    .cfg_bits(cfg_bits),
    .nonvolatile_write_busy(nonvolatile_write_busy)
  );

  assign meas_start = run_reg && !meas_busy && !meas_done;

  tsm_measure u_meas (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(meas_start),
    .lo_tick(lo_tick),
    .hi_tick(hi_tick),
    .busy(meas_busy),
    .done(meas_done),
    .temp(meas_temp),
    .count_remain(count_remain),
    .slope_value(slope_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode is caught one clock after reset release, never under reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_up_reg <= 1'b1;
      thermostat_reg <= 1'b0;
      pulse_cnt_reg <= 5'h00;
    end
    else if (ce)
    begin
      power_up_reg <= 1'b0;
      if (power_up_reg)
        thermostat_reg <= cfg_bits[CFG_MODE];
      if (!sync2_reg[3])
        pulse_cnt_reg <= 5'h00;
      else if (dq_fall)
      begin
        // the stored mode bit is left alone; only the running mode flips
        if (pulse_cnt_reg == RESTORE_PULSES - 5'h01)
        begin
          thermostat_reg <= !thermostat_reg;
          pulse_cnt_reg <= 5'h00;
        end
        else
          pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
      end
    end
  end

  // conversion run control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= TEMP_MIN;
    end
    else if (ce)
    begin
      if (power_up_reg)
        run_reg <= cfg_bits[CFG_MODE];
      else if (thermostat_reg)
        run_reg <= 1'b1;
      else if (stop_pulse)
        run_reg <= 1'b0;
      else if (start_pulse)
        run_reg <= 1'b1;
      else if (meas_done && single_conversion_select)
        run_reg <= 1'b0;
      if (start_pulse)
        done_reg <= 1'b0;
      else if (meas_done && single_conversion_select)
        done_reg <= 1'b1;
      if (meas_done)
        result_reg <= meas_temp;
    end
  end

  // trip flags: hardware set, software clear by writing zero; set wins
  always_ff @(posedge aclk)
  begin
    // flags outlive reset like the rest of storage; reset only blocks updates
    if (ce && aresetn)
    begin
      if (nv_req && nv_sel == NV_CFG && !nonvolatile_write_busy)
      begin
        high_limit_flag <= (meas_done && $signed(meas_temp) >= $signed(high_trip_point))
                           || (high_limit_flag && w_data_reg[CFG_HIFLAG]);
        low_limit_flag <= (meas_done && $signed(meas_temp) <= $signed(low_trip_point))
                          || (low_limit_flag && w_data_reg[CFG_LOFLAG]);
      end
      else if (meas_done)
      begin
        if ($signed(meas_temp) >= $signed(high_trip_point))
          high_limit_flag <= 1'b1;
        if ($signed(meas_temp) <= $signed(low_trip_point))
          low_limit_flag <= 1'b1;
      end
    end
  end

  // thermostat hysteresis, evaluated only on a finished conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      therm_active_reg <= 1'b0;
    else if (ce && meas_done)
    begin
      if ($signed(meas_temp) > $signed(high_trip_point))
        therm_active_reg <= 1'b1;
      else if ($signed(meas_temp) < $signed(low_trip_point))
        therm_active_reg <= 1'b0;
    end
  end

  // open-drain pin: only ever drives low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dq_out <= 1'b0;
      dq_oe <= 1'b0;
    end
    else if (ce)
    begin
      dq_out <= 1'b0;
      if (thermostat_reg)
        dq_oe <= (therm_active_reg != output_active_level);
      else
        dq_oe <= bus_pull_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_pin_low_only: assert property (@(posedge aclk) disable iff (!aresetn)
    dq_out == 1'b0) else $error("data pin driven high");
  chk_result_on_done: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_done && ce |=> result_reg == $past(meas_temp)) else $error("result not latched");
  chk_result_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(meas_done) && !$past(power_up_reg) |-> $stable(result_reg))
    else $error("result changed mid conversion");
  chk_therm_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_done && ce && $signed(meas_temp) > $signed(high_trip_point) |=> therm_active_reg)
    else $error("thermostat did not assert");
  chk_therm_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(meas_done) && !$past(power_up_reg) |-> $stable(therm_active_reg))
    else $error("thermostat changed without conversion");
  chk_pol_output: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && thermostat_reg && !power_up_reg |=> dq_oe == ($past(therm_active_reg)
    != $past(output_active_level))) else $error("wrong pin polarity");
  chk_therm_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && thermostat_reg && !power_up_reg |=> run_reg) else $error("thermostat not converting");
  chk_stop_halts: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && stop_pulse && !thermostat_reg && !power_up_reg |=> !run_reg)
    else $error("stop ignored");
  chk_busy_reports: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && nv_req && !nonvolatile_write_busy |=> nonvolatile_write_busy [*2])
    else $error("busy not reported");
  chk_temp_range: assert property (@(posedge aclk) disable iff (!aresetn)
    $signed(result_reg) >= $signed(TEMP_MIN) && $signed(result_reg) <= $signed(TEMP_MAX))
    else $error("result out of range");
  cov_conversion: cover property (@(posedge aclk) disable iff (!aresetn) meas_done);
  cov_nv_write: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(nonvolatile_write_busy));
  cov_thermostat: cover property (@(posedge aclk) disable iff (!aresetn)
    thermostat_reg && $rose(therm_active_reg));
  cov_restore: cover property (@(posedge aclk) disable iff (!aresetn) $changed(thermostat_reg)
    && !$past(power_up_reg));
endmodule

// [tb/tsm_far_model.sv]
// oscillator pair and pulled-up open-drain pin around the core
`timescale 1ns/1ps
module tsm_far_model (
  // pin
  input wire logic dq_oe,
  input wire logic host_pull_low,
  output logic dq_in,
  // oscillators
  output logic lo_tc_osc,
  output logic hi_tc_osc
);
  initial lo_tc_osc = 1'b0;
  initial hi_tc_osc = 1'b0;
  // odd half periods keep both unrelated to aclk; hi_tc_osc runs at exactly a third of the lo_tc_osc rate
  always #41 lo_tc_osc = ~lo_tc_osc;
  always #123 hi_tc_osc = ~hi_tc_osc;
  // released pin floats to the pull-up level
  assign dq_in = (dq_oe || host_pull_low) ? 1'b0 : 1'b1;
endmodule

// [tb/tb_top.sv]
// self-checking bench for the thermometer/thermostat core
`timescale 1ns/1ps
module tb_top
  import tsm_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, pull_lo = 1'b0;
  logic supply_lo = 1'b0, host_lo = 1'b0;
  logic [4:0] aw_a = 5'h00, ar_a = 5'h00;
  logic [31:0] w_d = 32'h0000_0000, rdata, v;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, dq_out, dq_oe, dq_in, lo_osc, hi_osc;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 aclk = ~aclk;
  tsm_core #(.NV_CYCLES(20)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .lo_tc_osc(lo_osc), .hi_tc_osc(hi_osc), .supply_low(supply_lo),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .bus_pull_low(pull_lo));
  tsm_far_model i_far (.dq_oe(dq_oe), .host_pull_low(host_lo), .dq_in(dq_in),
    .lo_tc_osc(lo_osc), .hi_tc_osc(hi_osc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // each channel is released only at the edge that takes it
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit pa = 1'b1;
    bit pw = 1'b1;
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && aw_rdy === 1'b1) aw_v <= 1'b0;
      if (pw && w_rdy === 1'b1) w_v <= 1'b0;
      pa = pa && aw_rdy !== 1'b1;
      pw = pw && w_rdy !== 1'b1;
    end
    do @(posedge aclk); while (b_v !== 1'b1);
    chk("bresp", {30'h0000_0000, bresp}, 32'h0000_0000);
    b_r <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge aclk); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge aclk); while (r_v !== 1'b1);
    d = rdata;
    chk("rresp", {30'h0000_0000, rresp}, 32'h0000_0000);
    r_r <= 1'b0;
  endtask
  // host side of the restore procedure: supply held low, then low pulses on the pin
  task automatic restore();
    supply_lo <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < RESTORE_PULSES; i++)
    begin
      host_lo <= 1'b1;
      repeat (4) @(posedge aclk);
      host_lo <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    supply_lo <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // a second slow write must wait for idle storage, so poll busy first
  task automatic nvw(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    wr(a, d);
    rd(OFS_STATUS, v);
    chk("nv busy", {31'h0000_0000, v[STS_BUSY]}, 32'h0000_0001);
    for (int i = 0; i < 40 && v[STS_BUSY] !== 1'b0; i++) rd(OFS_STATUS, v);
    chk("nv idle", {31'h0000_0000, v[STS_BUSY]}, 32'h0000_0000);
    rd(a, v);
    chk("nv readback", v & m, d);
  endtask
  task automatic wait_result();
    v = {24'h00_0000, TEMP_MIN};
    for (int i = 0; i < 5000 && v[7:0] === TEMP_MIN; i++) rd(OFS_STATUS, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(90000 * 20);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    rst();
    rd(OFS_STATUS, v);
    chk("reset result", {24'h00_0000, v[7:0]}, {24'h00_0000, TEMP_MIN});
    chk("reset mode", {31'h0000_0000, v[STS_MODE]}, 32'h0000_0000);
    rd(OFS_CONFIG, v);
    chk("factory cfg", {29'h0000_0000, v[2:0]}, 32'h0000_0000);
    rd(OFS_COUNTER, v);
    chk("counter", v, {23'h00_0000, BASE_COUNT});
    rd(OFS_SLOPE, v);
    chk("slope", v, {23'h00_0000, SLOPE_INIT});
    rd(5'h1c, v);
    chk("unmapped", v, 32'h0000_0000);
    @(posedge aclk);
    pull_lo <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("bus pull", {31'h0000_0000, dq_oe}, 32'h0000_0001);
    pull_lo <= 1'b0;
    nvw(OFS_HIGH_TRIP, 32'h0000_0080, 32'h0000_00ff);
    nvw(OFS_LOW_TRIP, 32'h0000_0080, 32'h0000_00ff);
    wr(OFS_CONTROL, 32'h0000_0001);
    wait_result();
    chk("bus conv", {31'h0000_0000, $signed(v[7:0]) > -55 && $signed(v[7:0]) <= 125},
      32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0002);
    rd(OFS_STATUS, v);
    chk("stopped", {31'h0000_0000, v[STS_RUN]}, 32'h0000_0000);
    nvw(OFS_CONFIG, 32'h0000_0001, 32'h0000_0007);
    rst();
    chk("pin before done", {31'h0000_0000, dq_oe}, 32'h0000_0000);
    rd(OFS_STATUS, v);
    chk("thermostat", {31'h0000_0000, v[STS_MODE]}, 32'h0000_0001);
    wait_result();
    chk("auto conv", {24'h00_0000, v[7:0]} !== {24'h00_0000, TEMP_MIN}, 32'h0000_0001);
    chk("trip low act", {31'h0000_0000, dq_oe}, 32'h0000_0001);
    nvw(OFS_CONFIG, 32'h0000_0003, 32'h0000_0007);
    for (int i = 0; i < 20000 && dq_oe !== 1'b0; i++) @(posedge aclk);
    chk("trip high act", {31'h0000_0000, dq_oe}, 32'h0000_0000);
    chk("drive level", {31'h0000_0000, dq_out}, 32'h0000_0000);
    restore();
    rd(OFS_STATUS, v);
    chk("restore bus", {31'h0000_0000, v[STS_MODE]}, 32'h0000_0000);
    rd(OFS_CONFIG, v);
    chk("stored mode", {31'h0000_0000, v[CFG_MODE]}, 32'h0000_0001);
    restore();
    rd(OFS_STATUS, v);
    chk("restore therm", {31'h0000_0000, v[STS_MODE]}, 32'h0000_0001);
    nvw(OFS_HIGH_TRIP, 32'h0000_007d, 32'h0000_00ff);
    nvw(OFS_LOW_TRIP, 32'h0000_007c, 32'h0000_00ff);
    for (int i = 0; i < 30000 && dq_oe !== 1'b1; i++) @(posedge aclk);
    chk("trip release", {31'h0000_0000, dq_oe}, 32'h0000_0001);
    complete_run();
  end
endmodule
